// ---- sfra_pkg.sv ----
// constants, register map and types for the simd/fp register aliasing block
`default_nettype none
package sfra_pkg;
  localparam int NREG = 8;
  localparam int IDX_W = 3;
  localparam int SIMD_W = 64;
  localparam int FP_W = 80;
  localparam int EXP_W = FP_W - SIMD_W;
  localparam logic [EXP_W-1:0] EXP_ONES = 16'hFFFF;
  localparam int TOP_LSB = 11;
  localparam int TOP_MSB = 13;
  localparam logic [2:0] TOP_ZERO = 3'h0;
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TAG = 8'h08;
  localparam logic [7:0] REG_CWORD = 8'h0C;
  localparam logic [7:0] REG_IPTR = 8'h10;
  localparam logic [7:0] REG_DPTR = 8'h14;
  localparam logic [7:0] REG_OPCODE = 8'h18;
  localparam logic [7:0] REG_IRQ_ST = 8'h1C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h20;
  localparam logic [7:0] REG_DSEL = 8'h24;
  localparam logic [7:0] REG_DLO = 8'h28;
  localparam logic [7:0] REG_DMID = 8'h2C;
  localparam logic [7:0] REG_DHI = 8'h30;
  // control_reg_zero field positions
  localparam int CTRL_MP = 1;
  localparam int CTRL_EM = 2;
  localparam int CTRL_TS = 3;
  localparam logic [3:0] CTRL_RST = 4'h2;
  // interrupt status/mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_UD = 0;
  localparam int IRQ_NM = 1;
  localparam int IRQ_EXEC = 2;
  localparam int OPC_W = 11;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] TAG_RST = 16'hFFFF;
  localparam logic [15:0] CWORD_RST = 16'h0000;
  localparam logic [31:0] ZERO32 = 32'h0;
  localparam logic [FP_W-1:0] DREG_RST = 80'h0;

  typedef enum logic [2:0] {
    SFRA_OP_READ = 3'b001,
    SFRA_OP_WRITE = 3'b010,
    SFRA_OP_CLEAR = 3'b100
  } sfra_op_t;

  function automatic logic [15:0] sfra_fill_tags(input logic [1:0] t);
    sfra_fill_tags = {NREG{t}};
  endfunction : sfra_fill_tags

  function automatic logic [15:0] sfra_top_clr(input logic [15:0] sw);
    sfra_top_clr = sw;
    sfra_top_clr[TOP_MSB:TOP_LSB] = TOP_ZERO;
  endfunction : sfra_top_clr
endpackage : sfra_pkg
`default_nettype wire

// ---- sfra_rf_if.sv ----
// carrier between the control core and the aliased data register store
`timescale 1ns/1ns
`default_nettype none
interface sfra_rf_if;
  logic simd_we;
  logic [2:0] simd_idx;
  logic [63:0] simd_wdata;
  logic fp_we;
  logic [2:0] fp_widx;
  logic [79:0] fp_wdata;
  logic [2:0] ridx_a;
  logic [2:0] ridx_b;
  logic [2:0] ridx_c;
  logic [79:0] rdata_a;
  logic [79:0] rdata_b;
  logic [79:0] rdata_c;
  modport core (output simd_we, simd_idx, simd_wdata, fp_we, fp_widx,
    fp_wdata, ridx_a, ridx_b, ridx_c, input rdata_a, rdata_b, rdata_c);
  modport store (input simd_we, simd_idx, simd_wdata, fp_we, fp_widx,
    fp_wdata, ridx_a, ridx_b, ridx_c, output rdata_a, rdata_b, rdata_c);
endinterface : sfra_rf_if
`default_nettype wire

// ---- sfra_gate.sv ----
// decides whether a simd instruction executes or faults
`timescale 1ns/1ns
`default_nettype none
module sfra_gate (
  // request
  input wire logic op_i,
  // control flags
  input wire logic soft_fpu_flag_i,
  input wire logic task_switched_flag_i,
  // verdict
  output logic exec_o,
  output logic ud_o,
  output logic nm_o
);
  assign ud_o = op_i & soft_fpu_flag_i;
  assign nm_o = op_i & ~soft_fpu_flag_i & task_switched_flag_i;
  assign exec_o = op_i & ~soft_fpu_flag_i & ~task_switched_flag_i;
endmodule : sfra_gate
`default_nettype wire

// ---- sfra_regfile.sv ----
// eight 80-bit physical data registers with the 64-bit simd alias
`timescale 1ns/1ns
`default_nettype none
module sfra_regfile (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // core side
  sfra_rf_if.store rf
);
  logic [79:0] mem_r [8];
  logic fp_ok;

  // a simd write to the same register in the same cycle takes precedence
  assign fp_ok = rf.fp_we & ~(rf.simd_we & (rf.simd_idx == rf.fp_widx));

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < sfra_pkg::NREG; i++) begin
        mem_r[i] <= sfra_pkg::DREG_RST;
      end
    end else begin
      if (rf.simd_we) begin
        mem_r[rf.simd_idx] <= {sfra_pkg::EXP_ONES, rf.simd_wdata};
      end
      if (fp_ok) begin
        mem_r[rf.fp_widx] <= rf.fp_wdata;
      end
    end
  end

  // fixed physical index, no stack-relative offset
  assign rf.rdata_a = mem_r[rf.ridx_a];
  assign rf.rdata_b = mem_r[rf.ridx_b];
  assign rf.rdata_c = mem_r[rf.ridx_c];
endmodule : sfra_regfile
`default_nettype wire

// ---- sfra_top.sv ----
// simd registers aliased onto the floating-point data registers
// Notes on behaviour
// - with the soft fpu flag set every simd instruction takes the invalid opcode fault, never emulated.
// - with soft fpu clear a simd instruction runs when task switched is 0 and takes the device unavailable fault when it is 1.
// - eight 64-bit simd registers live in bits 0 to 63 of the same-numbered physical data register.
// - the alias uses physical numbers and ignores the stack top field in status bits 11 to 13.
// - a simd write shows in bits 0 to 63 of the data register and a fp write shows its low 64 bits in the simd register.
// - a simd register write forces bits 64 to 79 of the aliased data register to ones in the same cycle.
// - every executed simd instruction except clear sets all tag fields to 00; a faulted one leaves the tags alone.
// - the clear instruction sets all tag fields to 11.
// - every executed simd instruction, reads and clear included, sets the stack top field to 000; a faulted one leaves it alone.
// - simd instructions keep status bits 0 to 10, 14, 15 and the control word, pointers and opcode.
// - simd reads and clear leave all 80 bits of every data register alone.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module sfra_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // simd instruction issue
  input wire logic op_valid_i,
  input wire logic [2:0] op_kind_i,
  input wire logic [2:0] op_idx_i,
  input wire logic [63:0] op_wdata_i,
  // floating-point unit data port
  input wire logic fp_we_i,
  input wire logic [2:0] fp_widx_i,
  input wire logic [79:0] fp_wdata_i,
  input wire logic [2:0] fp_ridx_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // results
  output logic [63:0] simd_rdata_o,
  output logic simd_rvalid_o,
  output logic [79:0] fp_rdata_o,
  output logic ud_fault_o,
  output logic nm_fault_o,
  output logic done_o,
  output logic irq_o
);
  sfra_rf_if rf ();

  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] tag_r;
  logic [15:0] tag_nxt;
  logic [15:0] cword_r;
  logic [31:0] iptr_r;
  logic [31:0] dptr_r;
  logic [10:0] opcode_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_st_nxt;
  logic [2:0] irq_mask_r;
  logic [2:0] dsel_r;
  logic [31:0] rdata_nxt;

  // instruction decode
  wire op_legal = (op_kind_i == sfra_pkg::SFRA_OP_READ)
    | (op_kind_i == sfra_pkg::SFRA_OP_WRITE)
    | (op_kind_i == sfra_pkg::SFRA_OP_CLEAR);
  wire op_req = op_valid_i & op_legal;
  wire is_write = op_kind_i == sfra_pkg::SFRA_OP_WRITE;
  wire is_clear = op_kind_i == sfra_pkg::SFRA_OP_CLEAR;
  wire exec_w;
  wire ud_w;
  wire nm_w;

  sfra_gate u_gate (
    .op_i(op_req),
    .soft_fpu_flag_i(ctrl_r[sfra_pkg::CTRL_EM]),
    .task_switched_flag_i(ctrl_r[sfra_pkg::CTRL_TS]),
    .exec_o(exec_w),
    .ud_o(ud_w),
    .nm_o(nm_w)
  );

  wire do_write = exec_w & is_write;
  wire do_read = exec_w & ~is_write & ~is_clear;
  wire do_clear = exec_w & is_clear;

  // data store
  sfra_regfile u_store (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .rf(rf)
  );

  // only an executed write reaches the store
  assign rf.simd_we = do_write;
  assign rf.simd_idx = op_idx_i;
  assign rf.simd_wdata = op_wdata_i;
  assign rf.fp_we = fp_we_i;
  assign rf.fp_widx = fp_widx_i;
  assign rf.fp_wdata = fp_wdata_i;
  assign rf.ridx_a = op_idx_i;
  assign rf.ridx_b = fp_ridx_i;
  assign rf.ridx_c = dsel_r;

  // register port decode
  wire wr_ctrl = wr_i & (addr_i == sfra_pkg::REG_CTRL);
  wire wr_status = wr_i & (addr_i == sfra_pkg::REG_STATUS);
  wire wr_tag = wr_i & (addr_i == sfra_pkg::REG_TAG);
  wire wr_cword = wr_i & (addr_i == sfra_pkg::REG_CWORD);
  wire wr_iptr = wr_i & (addr_i == sfra_pkg::REG_IPTR);
  wire wr_dptr = wr_i & (addr_i == sfra_pkg::REG_DPTR);
  wire wr_opcode = wr_i & (addr_i == sfra_pkg::REG_OPCODE);
  wire wr_irq_st = wr_i & (addr_i == sfra_pkg::REG_IRQ_ST);
  wire wr_irq_mask = wr_i & (addr_i == sfra_pkg::REG_IRQ_MASK);
  wire wr_dsel = wr_i & (addr_i == sfra_pkg::REG_DSEL);

  assign ctrl_nxt = wr_ctrl ? wdata_i[3:0] : ctrl_r;

  // stack top cleared by every executed simd op, other bits kept
  wire [15:0] status_base = wr_status ? wdata_i[15:0] : status_r;
  assign status_nxt = exec_w ? sfra_pkg::sfra_top_clr(status_base)
    : status_base;

  // hardware tag update wins over a same-cycle software write
  wire [15:0] tag_sw = wr_tag ? wdata_i[15:0] : tag_r;
  wire [15:0] tag_hw = do_clear
    ? sfra_pkg::sfra_fill_tags(sfra_pkg::TAG_EMPTY)
    : sfra_pkg::sfra_fill_tags(sfra_pkg::TAG_VALID);
  assign tag_nxt = exec_w ? tag_hw : tag_sw;

  // sticky events, write one to clear, new event wins
  wire [2:0] ev = {exec_w, nm_w, ud_w};
  wire [2:0] irq_clr = wr_irq_st ? wdata_i[2:0] : 3'h0;
  assign irq_st_nxt = (irq_st_r & ~irq_clr) | ev;

  // read selection
  wire [79:0] dreg = rf.rdata_c;
  assign rdata_nxt = !rd_i ? sfra_pkg::ZERO32
    : (addr_i == sfra_pkg::REG_CTRL) ? {28'h0, ctrl_r}
    : (addr_i == sfra_pkg::REG_STATUS) ? {16'h0, status_r}
    : (addr_i == sfra_pkg::REG_TAG) ? {16'h0, tag_r}
    : (addr_i == sfra_pkg::REG_CWORD) ? {16'h0, cword_r}
    : (addr_i == sfra_pkg::REG_IPTR) ? iptr_r
    : (addr_i == sfra_pkg::REG_DPTR) ? dptr_r
    : (addr_i == sfra_pkg::REG_OPCODE) ? {21'h0, opcode_r}
    : (addr_i == sfra_pkg::REG_IRQ_ST) ? {29'h0, irq_st_r}
    : (addr_i == sfra_pkg::REG_IRQ_MASK) ? {29'h0, irq_mask_r}
    : (addr_i == sfra_pkg::REG_DSEL) ? {29'h0, dsel_r}
    : (addr_i == sfra_pkg::REG_DLO) ? dreg[31:0]
    : (addr_i == sfra_pkg::REG_DMID) ? dreg[63:32]
    : (addr_i == sfra_pkg::REG_DHI) ? {16'h0, dreg[79:64]}
    : sfra_pkg::ZERO32;

  // fpu context registers: only the register port changes them
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cword_r <= sfra_pkg::CWORD_RST;
      iptr_r <= sfra_pkg::ZERO32;
      dptr_r <= sfra_pkg::ZERO32;
      opcode_r <= 11'h0;
    end else begin
      if (wr_cword) cword_r <= wdata_i[15:0];
      if (wr_iptr) iptr_r <= wdata_i;
      if (wr_dptr) dptr_r <= wdata_i;
      if (wr_opcode) opcode_r <= wdata_i[10:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= sfra_pkg::CTRL_RST;
      status_r <= sfra_pkg::STATUS_RST;
      tag_r <= sfra_pkg::TAG_RST;
      irq_st_r <= 3'h0;
      irq_mask_r <= 3'h0;
      dsel_r <= 3'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      tag_r <= tag_nxt;
      irq_st_r <= irq_st_nxt;
      if (wr_irq_mask) irq_mask_r <= wdata_i[2:0];
      if (wr_dsel) dsel_r <= wdata_i[2:0];
    end
  end

  // registered outputs
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= sfra_pkg::ZERO32;
      simd_rdata_o <= 64'h0;
      simd_rvalid_o <= 1'b0;
      fp_rdata_o <= sfra_pkg::DREG_RST;
      ud_fault_o <= 1'b0;
      nm_fault_o <= 1'b0;
      done_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      rdata_o <= rdata_nxt;
      simd_rdata_o <= do_read ? rf.rdata_a[63:0] : 64'h0;
      simd_rvalid_o <= do_read;
      fp_rdata_o <= rf.rdata_b;
      ud_fault_o <= ud_w;
      nm_fault_o <= nm_w;
      done_o <= exec_w;
      irq_o <= |(irq_st_nxt & irq_mask_r);
    end
  end
endmodule : sfra_top
`default_nettype wire

// ---- sfra_top_props.sv ----
// concurrent checks on the aliasing block's ports
`timescale 1ns/1ns
`default_nettype none
module sfra_top_props (
  // watched ports
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_kind_i,
  input wire logic [2:0] op_idx_i,
  input wire logic [63:0] op_wdata_i,
  input wire logic fp_we_i,
  input wire logic [2:0] fp_widx_i,
  input wire logic [79:0] fp_wdata_i,
  input wire logic [2:0] fp_ridx_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic simd_rvalid_o,
  input wire logic [79:0] fp_rdata_o,
  input wire logic ud_fault_o,
  input wire logic nm_fault_o,
  input wire logic done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic legal = op_valid_i && op_kind_i inside {3'h1, 3'h2, 3'h4};
  wire logic swr = legal && op_kind_i == 3'h2;
  wire logic [2:0] resp = {done_o, ud_fault_o, nm_fault_o};
  sequence s_fpw;
    fp_we_i && !op_valid_i ##1 !fp_we_i && !op_valid_i &&
      fp_ridx_i == $past(fp_widx_i);
  endsequence
  sequence s_sw;
    swr && !fp_we_i ##1 done_o && !fp_we_i && !op_valid_i &&
      fp_ridx_i == $past(op_idx_i);
  endsequence
  sequence s_quiet;
    (!fp_we_i && !swr && $stable(fp_ridx_i)) [*2];
  endsequence
  property p_resp; legal |=> $onehot(resp); endproperty
  a_resp: assert property (p_resp) else $error("verdict not single");
  property p_none; !legal |=> resp == 3'h0; endproperty
  a_none: assert property (p_none) else $error("verdict without op");
  property p_rd; legal && op_kind_i == 3'h1 |=> simd_rvalid_o == done_o; endproperty
  a_rd: assert property (p_rd) else $error("read result lost");
  property p_rv; !(legal && op_kind_i == 3'h1) |=> !simd_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("stray read valid");
  property p_fpw; s_fpw |=> fp_rdata_o == $past(fp_wdata_i, 2); endproperty
  a_fpw: assert property (p_fpw) else $error("fp write not stored");
  property p_sw;
    s_sw |=> fp_rdata_o == {sfra_pkg::EXP_ONES, $past(op_wdata_i, 2)};
  endproperty
  a_sw: assert property (p_sw) else $error("simd write alias wrong");
  property p_hold; s_quiet |=> $stable(fp_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("data reg changed");
  property p_rdat; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rdat: assert property (p_rdat) else $error("read data not idle");
endmodule : sfra_top_props
`default_nettype wire

// ---- sfra_fpu_model.sv ----
// behavioural floating-point unit driving the data write port
`timescale 1ns/1ns
`default_nettype none
module sfra_fpu_model (
  // clock and request
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [2:0] idx_i,
  input wire logic [79:0] data_i,
  // write port
  output logic fp_we_o,
  output logic [2:0] fp_widx_o,
  output logic [79:0] fp_wdata_o
);
  initial fp_we_o = 1'b0;
  initial fp_widx_o = 3'h0;
  initial fp_wdata_o = 80'h0;
  // idle cycles toggle index and data so stale values are never trusted
  always @(posedge mclk_i) begin
    fp_we_o <= go_i;
    fp_widx_o <= go_i ? idx_i : ~fp_widx_o;
    fp_wdata_o <= go_i ? data_i : ~fp_wdata_o;
  end
endmodule : sfra_fpu_model
`default_nettype wire

// ---- sfra_tb.sv ----
// self-checking bench for the simd/fp aliasing block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [2:0] kind;
    logic [2:0] resp;
    logic [15:0] tag;
    logic [15:0] sw;
  } sfra_row_t;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, op_valid_i = 1'b0, go = 1'b0;
  logic wr_i = 1'b0, rd_i = 1'b0, fp_we_i, simd_rvalid_o;
  logic ud_fault_o, nm_fault_o, done_o, irq_o;
  logic [2:0] op_kind_i = 3'h0, op_idx_i = 3'h0, fp_ridx_i = 3'h0;
  logic [2:0] gidx = 3'h0, fp_widx_i;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [63:0] op_wdata_i = 64'h0, simd_rdata_o;
  logic [79:0] gdata = 80'h0, fp_wdata_i, fp_rdata_o;
  int fails = 0, n_tests = 0;
  sfra_row_t rows [6] = '{ // ctrl bit 1 kept set
    '{4'h2, 3'h2, 3'h4, 16'h0000, 16'hC7FF}, '{4'hA, 3'h2, 3'h1, 16'h5555,
    16'hFFFF}, '{4'h6, 3'h1, 3'h2, 16'h5555, 16'hFFFF}, '{4'hE, 3'h4, 3'h2,
    16'h5555, 16'hFFFF}, '{4'h2, 3'h4, 3'h4, 16'hFFFF, 16'hC7FF},
    '{4'h3, 3'h1, 3'h4, 16'h0000, 16'hC7FF}};
  sfra_top sfra_top_i (.mclk_i, .rst_b_i, .op_valid_i, .op_kind_i,
    .op_idx_i, .op_wdata_i, .fp_we_i, .fp_widx_i, .fp_wdata_i, .fp_ridx_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .simd_rdata_o,
    .simd_rvalid_o, .fp_rdata_o, .ud_fault_o, .nm_fault_o, .done_o, .irq_o);
  sfra_fpu_model sfra_fpu_model_i (.mclk_i, .go_i(go), .idx_i(gidx),
    .data_i(gdata), .fp_we_o(fp_we_i), .fp_widx_o(fp_widx_i),
    .fp_wdata_o(fp_wdata_i));
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk({48'h0, rdata_o}, {48'h0, e});
  endtask : rd
  task automatic op(input logic [2:0] k, input logic [2:0] i,
    input logic [63:0] d);
    @(posedge mclk_i);
    op_valid_i <= 1'b1;
    op_kind_i <= k;
    op_idx_i <= i;
    op_wdata_i <= d;
    @(posedge mclk_i);
    op_valid_i <= 1'b0;
    #1;
  endtask : op
  task automatic fpw(input logic [2:0] i, input logic [79:0] d);
    @(posedge mclk_i);
    go <= 1'b1;
    gidx <= i;
    gdata <= d;
    @(posedge mclk_i);
    go <= 1'b0;
  endtask : fpw
  task automatic fpr(input logic [2:0] i, input logic [79:0] e);
    @(posedge mclk_i);
    fp_ridx_i <= i;
    @(posedge mclk_i);
    #1 chk(fp_rdata_o, e);
  endtask : fpr
  task automatic give_verdict;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial forever #2 mclk_i = ~mclk_i;
  initial begin
    #200000 fails++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(sfra_pkg::REG_CTRL, 32'h2);
    rd(sfra_pkg::REG_TAG, 32'hFFFF);
    wr(8'h40, 32'h1);
    rd(8'h40, 32'h0);
    wr(sfra_pkg::REG_CWORD, 32'h1234);
    foreach (rows[n]) begin
      wr(sfra_pkg::REG_CTRL, {28'h0, rows[n].ctrl});
      wr(sfra_pkg::REG_TAG, 32'h5555);
      wr(sfra_pkg::REG_STATUS, 32'hFFFF);
      op(rows[n].kind, 3'h1, 64'h0);
      chk({done_o, ud_fault_o, nm_fault_o}, rows[n].resp);
      rd(sfra_pkg::REG_TAG, rows[n].tag);
      rd(sfra_pkg::REG_STATUS, rows[n].sw);
    end
    op(3'h3, 3'h1, 64'h0);
    chk({done_o, ud_fault_o, nm_fault_o}, 3'h0);
    rd(sfra_pkg::REG_CWORD, 32'h1234);
    wr(sfra_pkg::REG_STATUS, 32'h3800);
    // read index parked on the target so the alias check sees the write
    fpr(3'h5, 80'h0);
    op(3'h2, 3'h5, 64'h0123456789ABCDEF);
    fpr(3'h5, 80'hFFFF0123456789ABCDEF);
    fpw(3'h6, 80'hA5A50011223344556677);
    fpr(3'h6, 80'hA5A50011223344556677);
    op(3'h1, 3'h6, 64'h0);
    chk(simd_rdata_o, 80'h0011223344556677);
    chk(simd_rvalid_o, 1'b1);
    fpr(3'h6, 80'hA5A50011223344556677);
    op(3'h4, 3'h5, 64'h0);
    fpr(3'h5, 80'hFFFF0123456789ABCDEF);
    rd(sfra_pkg::REG_IRQ_ST, 32'h7);
    chk(irq_o, 1'b0);
    wr(sfra_pkg::REG_IRQ_MASK, 32'h2);
    @(posedge mclk_i);
    #1 chk(irq_o, 1'b1);
    wr(sfra_pkg::REG_IRQ_ST, 32'h7);
    @(posedge mclk_i);
    #1 chk(irq_o, 1'b0);
    rst_b_i <= 1'b0;
    @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(sfra_pkg::REG_TAG, 32'hFFFF);
    give_verdict();
  end
endmodule : testbench
bind sfra_top sfra_top_props sfra_top_props_i (.mclk_i, .rst_b_i,
  .op_valid_i, .op_kind_i, .op_idx_i, .op_wdata_i, .fp_we_i, .fp_widx_i,
  .fp_wdata_i, .fp_ridx_i, .rd_i, .rdata_o, .simd_rvalid_o, .fp_rdata_o,
  .ud_fault_o, .nm_fault_o, .done_o);
`default_nettype wire
